/* File: cpu_exec_pkg.sv */
package cpu_exec_pkg;

  // ----------------------------------------------------------------
  // Widths and timing
  // ----------------------------------------------------------------
  localparam int DATA_W     = 16;
  localparam int PC_W       = 16;
  localparam int BIT_W      = 4;
  localparam int LIT5_W     = 5;
  localparam int LIT10_W    = 10;
  localparam int CNT_W      = 2;
  localparam logic [PC_W-1:0] PC_STEP = 16'h0002;
  localparam logic [CNT_W-1:0] BRANCH_EXTRA = 2'h1;
  localparam logic [CNT_W-1:0] SKIP1_EXTRA  = 2'h1;
  localparam logic [CNT_W-1:0] SKIP2_EXTRA  = 2'h2;

  // ----------------------------------------------------------------
  // Decoded operations and operand forms
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    nop_op, add_op, add_with_carry_op, and_op, arith_shift_right_op,
    asr_multi_op, bit_clear_op, bit_set_op, bit_toggle_op,
    flag_to_bit_write_op, bit_test_skip_clear_op, branch_op,
    branch_always_op, branch_computed_op
  } op_t;

  typedef enum logic [2:0] {
    form_f, form_f_accum, form_lit10, form_default_accumulator_reg, form_lit5
  } form_t;

  typedef enum logic [3:0] {
    cond_c, cond_nc, cond_n, cond_nn, cond_ov, cond_nov, cond_z,
    cond_nz, cond_gt, cond_ge, cond_lt, cond_le, cond_gtu, cond_geu,
    cond_ltu, cond_leu
  } cond_t;

  typedef enum logic [1:0] {tgt_file, tgt_accum, tgt_default_accumulator_reg} tgt_t;

  typedef struct packed {
    logic c;
    logic dc;
    logic n;
    logic ov;
    logic z;
  } flags_t;

  localparam flags_t FLAGS_RST = '0;

  typedef struct packed {
    op_t                op;
    form_t              form;
    cond_t              cond;
    logic               sel_z;
    logic [BIT_W-1:0]   bit_pos;
    logic [LIT10_W-1:0] lit;
    logic [DATA_W-1:0]  opa;
    logic [DATA_W-1:0]  opb;
    logic [DATA_W-1:0]  dst_addr;
    logic [PC_W-1:0]    pc;
    logic [PC_W-1:0]    target;
  } insn_t;

  typedef struct packed {
    logic              en;
    tgt_t              tgt;
    logic [DATA_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } wb_t;

endpackage : cpu_exec_pkg

/* File: cpu_insn_subset_exec.sv */
`timescale 1ns/10ps
module cpu_insn_subset_exec (
  input  wire logic                           clk_sys,
  input  wire logic                           rst_n,
  input  wire logic                           insn_valid,
  input  wire cpu_exec_pkg::insn_t            insn,
  input  wire logic                           next_two_word,
  output logic                                insn_ready,
  output cpu_exec_pkg::wb_t                   wb,
  output cpu_exec_pkg::flags_t                flags,
  output logic                                redirect,
  output logic [cpu_exec_pkg::PC_W-1:0]       redirect_pc,
  output logic                                flush
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                           ready;
    logic [cpu_exec_pkg::CNT_W-1:0] cnt;
    cpu_exec_pkg::wb_t              wb;
    cpu_exec_pkg::flags_t           flags;
    logic                           redirect;
    logic [cpu_exec_pkg::PC_W-1:0]  redirect_pc;
    logic                           flush;
  } state_t;

  state_t s;
  state_t next_s;

  logic                              accept;
  logic [cpu_exec_pkg::DATA_W-1:0]   opnd_b;
  logic                              take;

  assign accept = insn_valid && s.ready;

  // ----------------------------------------------------------------
  // Decoding helpers
  // ----------------------------------------------------------------
  function automatic cpu_exec_pkg::tgt_t dest_of(
    input cpu_exec_pkg::form_t form);
    unique case (form)
      cpu_exec_pkg::form_f:       dest_of = cpu_exec_pkg::tgt_file;
      cpu_exec_pkg::form_f_accum: dest_of = cpu_exec_pkg::tgt_accum;
      default:                    dest_of = cpu_exec_pkg::tgt_default_accumulator_reg;
    endcase
  endfunction : dest_of

  function automatic logic cond_true(input cpu_exec_pkg::cond_t cond,
                                     input cpu_exec_pkg::flags_t f);
    unique case (cond)
      cpu_exec_pkg::cond_c:   cond_true = f.c;
      cpu_exec_pkg::cond_nc:  cond_true = !f.c;
      cpu_exec_pkg::cond_n:   cond_true = f.n;
      cpu_exec_pkg::cond_nn:  cond_true = !f.n;
      cpu_exec_pkg::cond_ov:  cond_true = f.ov;
      cpu_exec_pkg::cond_nov: cond_true = !f.ov;
      cpu_exec_pkg::cond_z:   cond_true = f.z;
      cpu_exec_pkg::cond_nz:  cond_true = !f.z;
      cpu_exec_pkg::cond_gt:  cond_true = !f.z && (f.n == f.ov);
      cpu_exec_pkg::cond_ge:  cond_true = (f.n == f.ov);
      cpu_exec_pkg::cond_lt:  cond_true = (f.n != f.ov);
      cpu_exec_pkg::cond_le:  cond_true = f.z || (f.n != f.ov);
      cpu_exec_pkg::cond_gtu: cond_true = f.c && !f.z;
      cpu_exec_pkg::cond_geu: cond_true = f.c;
      cpu_exec_pkg::cond_ltu: cond_true = !f.c;
      cpu_exec_pkg::cond_leu: cond_true = !f.c || f.z;
    endcase
  endfunction : cond_true

  // ----------------------------------------------------------------
  // Second operand: literal forms replace the register value.
  // ----------------------------------------------------------------
  always_comb begin
    unique case (insn.form)
      cpu_exec_pkg::form_lit10: opnd_b = {6'h00, insn.lit};
      cpu_exec_pkg::form_lit5:  opnd_b = {11'h000, insn.lit[4:0]};
      default:                  opnd_b = insn.opb;
    endcase
  end

  // ----------------------------------------------------------------
  // Flow decision for branches and the bit-test skip
  // ----------------------------------------------------------------
  always_comb begin
    unique case (insn.op)
      cpu_exec_pkg::branch_op:
        take = cond_true(insn.cond, s.flags);
      cpu_exec_pkg::branch_always_op,
      cpu_exec_pkg::branch_computed_op:
        take = 1'b1;
      cpu_exec_pkg::bit_test_skip_clear_op:
        take = !insn.opa[insn.bit_pos];
      default:
        take = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [cpu_exec_pkg::DATA_W:0] sum;
    logic [4:0]                    nib;
    logic                          cin;
    logic [cpu_exec_pkg::DATA_W-1:0] res;
    logic [3:0]                    shamt;
    sum   = '0;
    nib   = '0;
    cin   = 1'b0;
    res   = '0;
    shamt = '0;
    next_s = s;
    next_s.wb.en    = 1'b0;
    next_s.redirect = 1'b0;
    next_s.flush    = 1'b0;
    if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 2'h1;
    end
    if (accept) begin
      next_s.wb.addr = insn.dst_addr;
      next_s.wb.tgt  = dest_of(insn.form);
      unique case (insn.op)
        cpu_exec_pkg::add_op,
        cpu_exec_pkg::add_with_carry_op: begin
          cin = (insn.op == cpu_exec_pkg::add_with_carry_op)
                ? s.flags.c : 1'b0;
          sum = {1'b0, insn.opa} + {1'b0, opnd_b}
                + {16'h0000, cin};
          nib = {1'b0, insn.opa[3:0]} + {1'b0, opnd_b[3:0]}
                + {4'h0, cin};
          res = sum[15:0];
          next_s.wb.en    = 1'b1;
          next_s.wb.data  = res;
          next_s.flags.c  = sum[16];
          next_s.flags.dc = nib[4];
          next_s.flags.n  = res[15];
          next_s.flags.ov = (insn.opa[15] == opnd_b[15])
                            && (res[15] != insn.opa[15]);
          next_s.flags.z  = (res == '0);
        end
        cpu_exec_pkg::and_op: begin
          res = insn.opa & opnd_b;
          next_s.wb.en   = 1'b1;
          next_s.wb.data = res;
          next_s.flags.n = res[15];
          next_s.flags.z = (res == '0);
        end
        cpu_exec_pkg::arith_shift_right_op: begin
          res = {insn.opa[15], insn.opa[15:1]};
          next_s.wb.en    = 1'b1;
          next_s.wb.data  = res;
          next_s.flags.c  = insn.opa[0];
          next_s.flags.n  = res[15];
          next_s.flags.ov = 1'b0;
          next_s.flags.z  = (res == '0);
        end
        cpu_exec_pkg::asr_multi_op: begin
          shamt = (insn.form == cpu_exec_pkg::form_lit5)
                  ? insn.lit[3:0] : insn.opb[3:0];
          res = 16'($signed(insn.opa) >>> shamt);
          next_s.wb.en   = 1'b1;
          next_s.wb.tgt  = cpu_exec_pkg::tgt_default_accumulator_reg;
          next_s.wb.data = res;
          next_s.flags.n = res[15];
          next_s.flags.z = (res == '0);
        end
        cpu_exec_pkg::bit_clear_op,
        cpu_exec_pkg::bit_set_op,
        cpu_exec_pkg::bit_toggle_op: begin
          res = insn.opa;
          if (insn.op == cpu_exec_pkg::bit_clear_op) begin
            res[insn.bit_pos] = 1'b0;
          end else if (insn.op == cpu_exec_pkg::bit_set_op) begin
            res[insn.bit_pos] = 1'b1;
          end else begin
            res[insn.bit_pos] = !insn.opa[insn.bit_pos];
          end
          next_s.wb.en   = 1'b1;
          next_s.wb.data = res;
        end
        cpu_exec_pkg::flag_to_bit_write_op: begin
          res = insn.opa;
          res[insn.opb[3:0]] = insn.sel_z ? s.flags.z : s.flags.c;
          next_s.wb.en   = 1'b1;
          next_s.wb.tgt  = cpu_exec_pkg::tgt_default_accumulator_reg;
          next_s.wb.data = res;
        end
        default: begin
          next_s.wb.en = 1'b0;
        end
      endcase
      if (take) begin
        next_s.flush    = 1'b1;
        next_s.redirect = 1'b1;
        if (insn.op == cpu_exec_pkg::bit_test_skip_clear_op) begin
          next_s.cnt = next_two_word ? cpu_exec_pkg::SKIP2_EXTRA
                                     : cpu_exec_pkg::SKIP1_EXTRA;
          next_s.redirect_pc = insn.pc + cpu_exec_pkg::PC_STEP
                               + (next_two_word ? 16'h0004 : 16'h0002);
        end else if (insn.op == cpu_exec_pkg::branch_computed_op) begin
          next_s.cnt = cpu_exec_pkg::BRANCH_EXTRA;
          next_s.redirect_pc = insn.pc + cpu_exec_pkg::PC_STEP
                               + {insn.opa[14:0], 1'b0};
        end else begin
          next_s.cnt = cpu_exec_pkg::BRANCH_EXTRA;
          next_s.redirect_pc = insn.target;
        end
      end
    end
    next_s.ready = (next_s.cnt == '0);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s       <= '0;
      s.ready <= 1'b1;
      s.flags <= cpu_exec_pkg::FLAGS_RST;
    end else begin
      s <= next_s;
    end
  end

  assign insn_ready  = s.ready;
  assign wb          = s.wb;
  assign flags       = s.flags;
  assign redirect    = s.redirect;
  assign redirect_pc = s.redirect_pc;
  assign flush       = s.flush;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_add_sum: assert property (
    accept && insn.op == cpu_exec_pkg::add_op |=> wb.en &&
    {flags.c, wb.data} == {1'b0, $past(insn.opa)} + {1'b0, $past(opnd_b)})
    else $error("add result or carry wrong");

  chk_adc_carry_in: assert property (
    accept && insn.op == cpu_exec_pkg::add_with_carry_op |=>
    wb.data == 16'($past(insn.opa) + $past(opnd_b) + $past(flags.c)))
    else $error("add with carry ignored carry");

  chk_and_keep: assert property (
    accept && insn.op == cpu_exec_pkg::and_op |=>
    {flags.c, flags.dc, flags.ov} == $past({flags.c, flags.dc, flags.ov})
    && wb.data == ($past(insn.opa) & $past(opnd_b)))
    else $error("and changed wrong flags");

  chk_asr_sign: assert property (
    accept && insn.op == cpu_exec_pkg::arith_shift_right_op |=>
    wb.data[15] == $past(insn.opa[15]) && flags.c == $past(insn.opa[0]))
    else $error("shift lost sign or carry");

  chk_asrm_flags: assert property (
    accept && insn.op == cpu_exec_pkg::asr_multi_op |=>
    $stable({flags.c, flags.dc, flags.ov}))
    else $error("multi shift touched carry");

  chk_bitop_flags: assert property (
    accept && insn.op inside {cpu_exec_pkg::bit_clear_op,
      cpu_exec_pkg::bit_set_op, cpu_exec_pkg::bit_toggle_op} |=>
    $stable(flags) && wb.en)
    else $error("bit op changed flags");

  chk_taken_two: assert property (
    accept && take && insn.op != cpu_exec_pkg::bit_test_skip_clear_op
    |=> redirect && flush && !insn_ready ##1 insn_ready && $stable(flags))
    else $error("taken branch not two cycles");

  chk_not_taken: assert property (
    accept && insn.op == cpu_exec_pkg::branch_op && !take |=>
    insn_ready && !redirect && $stable(flags))
    else $error("untaken branch stalled");

  chk_flag_bit: assert property (
    accept && insn.op == cpu_exec_pkg::flag_to_bit_write_op |=>
    wb.data[$past(insn.opb[3:0])] ==
    ($past(insn.sel_z) ? $past(flags.z) : $past(flags.c)))
    else $error("flag not copied to bit");

  chk_skip_three: assert property (
    accept && take && next_two_word &&
    insn.op == cpu_exec_pkg::bit_test_skip_clear_op |=>
    flush && !insn_ready ##1 !insn_ready ##1 insn_ready)
    else $error("two-word skip not three cycles");

  cov_branch_taken: cover property (
    accept && insn.op == cpu_exec_pkg::branch_op && take);
  cov_skip_two_word: cover property (
    accept && insn.op == cpu_exec_pkg::bit_test_skip_clear_op
    && take && next_two_word);
  cov_adc_carry: cover property (
    accept && insn.op == cpu_exec_pkg::add_with_carry_op && flags.c);

endmodule : cpu_insn_subset_exec

/* File: test_cpu_insn_subset_exec.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares += 1; if ((g) !== (e)) begin \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); \
  fail_count += 1; end end

module test_cpu_insn_subset_exec;
  typedef struct {
    cpu_exec_pkg::insn_t  i;
    logic [15:0]          d;
    cpu_exec_pkg::tgt_t   t;
    cpu_exec_pkg::flags_t f;
  } row_t;

  logic                             clk_sys;
  logic                             rst_n;
  logic                             insn_valid;
  cpu_exec_pkg::insn_t              insn;
  logic                             next_two_word;
  logic                             insn_ready;
  cpu_exec_pkg::wb_t                wb;
  cpu_exec_pkg::flags_t             flags;
  logic                             redirect;
  logic [cpu_exec_pkg::PC_W-1:0]    redirect_pc;
  logic                             flush;
  int                               fail_count;
  int                               compares;
  row_t                             rows [15];
  cpu_exec_pkg::insn_t              bi;

  cpu_insn_subset_exec u_dut (
    .clk_sys       (clk_sys),
    .rst_n         (rst_n),
    .insn_valid    (insn_valid),
    .insn          (insn),
    .next_two_word (next_two_word),
    .insn_ready    (insn_ready),
    .wb            (wb),
    .flags         (flags),
    .redirect      (redirect),
    .redirect_pc   (redirect_pc),
    .flush         (flush)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  function automatic cpu_exec_pkg::insn_t mk(cpu_exec_pkg::op_t op,
      cpu_exec_pkg::form_t fm, logic [15:0] a, logic [15:0] b,
      logic [9:0] lit, logic [3:0] bp, logic sz);
    mk          = '0;
    mk.op       = op;
    mk.form     = fm;
    mk.opa      = a;
    mk.opb      = b;
    mk.lit      = lit;
    mk.bit_pos  = bp;
    mk.sel_z    = sz;
    mk.dst_addr = 16'h0040;
    mk.pc       = 16'h0100;
    mk.target   = 16'h0200;
  endfunction : mk

  // Reference branch condition, indexed by the condition code.
  function automatic logic taken(cpu_exec_pkg::cond_t c,
      cpu_exec_pkg::flags_t f);
    logic [15:0] t;
    t = {!f.c || f.z, !f.c, f.c, f.c && !f.z, f.z || (f.n != f.ov),
         f.n != f.ov, f.n == f.ov, !f.z && (f.n == f.ov), !f.z, f.z,
         !f.ov, f.ov, !f.n, f.n, !f.c, f.c};
    return t[c];
  endfunction : taken

  task automatic drive(cpu_exec_pkg::insn_t i, logic ntw);
    @(posedge clk_sys);
    insn_valid    <= 1'b1;
    insn          <= i;
    next_two_word <= ntw;
    @(posedge clk_sys);
    insn_valid <= 1'b0;
    #1;
  endtask : drive

  task automatic br(cpu_exec_pkg::insn_t i, logic tk, logic [15:0] tgt,
      cpu_exec_pkg::flags_t f);
    drive(i, 1'b0);
    `CHK("redirect", tk, redirect)
    `CHK("flush", tk, flush)
    `CHK("ready stall", !tk, insn_ready)
    `CHK("wb idle", 1'b0, wb.en)
    `CHK("flags kept", f, flags)
    if (tk) `CHK("redirect pc", tgt, redirect_pc)
    @(posedge clk_sys);
    #1;
    `CHK("redirect pulse", 1'b0, redirect)
    `CHK("ready back", 1'b1, insn_ready)
  endtask : br

  task automatic complete_run;
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  initial begin
    #100000;
    fail_count += 1;
    complete_run();
  end

  initial begin
    fail_count    = 0;
    compares      = 0;
    rst_n         = 1'b0;
    insn_valid    = 1'b0;
    insn          = '0;
    next_two_word = 1'b0;
    rows = '{
      '{mk(cpu_exec_pkg::add_op, cpu_exec_pkg::form_default_accumulator_reg, 16'h7fff,
        16'h0001, 0, 0, 0), 16'h8000, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h0e},
      '{mk(cpu_exec_pkg::add_with_carry_op, cpu_exec_pkg::form_default_accumulator_reg,
        16'hffff, 16'h0001, 0, 0, 0), 16'h0000, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h19},
      '{mk(cpu_exec_pkg::add_with_carry_op, cpu_exec_pkg::form_default_accumulator_reg,
        16'h0001, 16'h0001, 0, 0, 0), 16'h0003, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h00},
      '{mk(cpu_exec_pkg::add_op, cpu_exec_pkg::form_f, 16'h8000,
        16'h8000, 0, 0, 0), 16'h0000, cpu_exec_pkg::tgt_file, 5'h13},
      '{mk(cpu_exec_pkg::and_op, cpu_exec_pkg::form_f_accum, 16'hff00,
        16'h8f0f, 0, 0, 0), 16'h8f00, cpu_exec_pkg::tgt_accum, 5'h16},
      '{mk(cpu_exec_pkg::arith_shift_right_op, cpu_exec_pkg::form_default_accumulator_reg,
        16'h8001, 0, 0, 0, 0), 16'hc000, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h14},
      '{mk(cpu_exec_pkg::asr_multi_op, cpu_exec_pkg::form_default_accumulator_reg, 16'h0010,
        16'h0005, 0, 0, 0), 16'h0000, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h11},
      '{mk(cpu_exec_pkg::bit_set_op, cpu_exec_pkg::form_default_accumulator_reg, 16'h0000,
        0, 0, 4'hf, 0), 16'h8000, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h11},
      '{mk(cpu_exec_pkg::bit_clear_op, cpu_exec_pkg::form_f, 16'hffff,
        0, 0, 4'h0, 0), 16'hfffe, cpu_exec_pkg::tgt_file, 5'h11},
      '{mk(cpu_exec_pkg::bit_toggle_op, cpu_exec_pkg::form_default_accumulator_reg, 16'h00f0,
        0, 0, 4'h4, 0), 16'h00e0, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h11},
      '{mk(cpu_exec_pkg::flag_to_bit_write_op, cpu_exec_pkg::form_default_accumulator_reg,
        16'h0000, 16'h0003, 0, 0, 0), 16'h0008, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h11},
      '{mk(cpu_exec_pkg::flag_to_bit_write_op, cpu_exec_pkg::form_default_accumulator_reg,
        16'h0000, 16'h000f, 0, 0, 1), 16'h8000, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h11},
      '{mk(cpu_exec_pkg::add_op, cpu_exec_pkg::form_default_accumulator_reg, 16'h0001,
        16'h0001, 0, 0, 0), 16'h0002, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h00},
      '{mk(cpu_exec_pkg::add_op, cpu_exec_pkg::form_lit10, 16'h0100,
        0, 10'h3ff, 0, 0), 16'h04ff, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h00},
      '{mk(cpu_exec_pkg::add_with_carry_op, cpu_exec_pkg::form_lit5,
        16'h000f, 0, 10'h01f, 0, 0), 16'h002e, cpu_exec_pkg::tgt_default_accumulator_reg, 5'h08}};
    repeat (3) @(posedge clk_sys);
    #1;
    `CHK("reset ready", 1'b1, insn_ready)
    `CHK("reset wb", '0, wb)
    `CHK("reset flags", 5'h00, flags)
    `CHK("reset redirect", 1'b0, redirect | flush)
    @(posedge clk_sys);
    rst_n <= 1'b1;
    foreach (rows[k]) begin
      drive(rows[k].i, 1'b0);
      `CHK("wb enable", 1'b1, wb.en)
      `CHK("wb data", rows[k].d, wb.data)
      `CHK("wb target", rows[k].t, wb.tgt)
      `CHK("wb address", 16'h0040, wb.addr)
      `CHK("flags", rows[k].f, flags)
      `CHK("one cycle", 1'b1, insn_ready)
    end
    // ----------------------------------------------------------------
    // Branches under two flag states
    // ----------------------------------------------------------------
    for (int c = 0; c < 16; c++) begin
      bi      = mk(cpu_exec_pkg::branch_op, cpu_exec_pkg::form_f, 0, 0, 0,
                   0, 0);
      bi.cond = cpu_exec_pkg::cond_t'(c);
      br(bi, taken(bi.cond, 5'h08), 16'h0200, 5'h08);
    end
    drive(rows[3].i, 1'b0);
    for (int c = 0; c < 16; c++) begin
      bi      = mk(cpu_exec_pkg::branch_op, cpu_exec_pkg::form_f, 0, 0, 0,
                   0, 0);
      bi.cond = cpu_exec_pkg::cond_t'(c);
      br(bi, taken(bi.cond, 5'h13), 16'h0200, 5'h13);
    end
    br(mk(cpu_exec_pkg::branch_always_op, cpu_exec_pkg::form_f, 0, 0, 0,
          0, 0), 1'b1, 16'h0200, 5'h13);
    br(mk(cpu_exec_pkg::branch_computed_op, cpu_exec_pkg::form_default_accumulator_reg,
          16'h0010, 0, 0, 0, 0), 1'b1, 16'h0122, 5'h13);
    // ----------------------------------------------------------------
    // Bit test skips, refused request during the stall
    // ----------------------------------------------------------------
    bi = mk(cpu_exec_pkg::bit_test_skip_clear_op, cpu_exec_pkg::form_default_accumulator_reg,
            16'hfffe, 0, 0, 4'h1, 0);
    br(bi, 1'b0, 16'h0000, 5'h13);
    bi.bit_pos = 4'h0;
    br(bi, 1'b1, 16'h0104, 5'h13);
    @(posedge clk_sys);
    insn_valid    <= 1'b1;
    insn          <= bi;
    next_two_word <= 1'b1;
    @(posedge clk_sys);
    insn <= rows[12].i;
    #1;
    `CHK("skip pc", 16'h0106, redirect_pc)
    `CHK("skip flush", 1'b1, flush & redirect)
    `CHK("skip stall 1", 1'b0, insn_ready)
    @(posedge clk_sys);
    #1;
    `CHK("skip stall 2", 1'b0, insn_ready)
    `CHK("refused", 1'b0, wb.en)
    @(posedge clk_sys);
    #1;
    `CHK("skip done", 1'b1, insn_ready)
    `CHK("still refused", 1'b0, wb.en)
    @(posedge clk_sys);
    insn_valid <= 1'b0;
    #1;
    `CHK("taken late", 16'h0002, wb.data & {16{wb.en}})
    @(posedge clk_sys);
    #1;
    `CHK("taken once", 1'b0, wb.en)
    // ----------------------------------------------------------------
    // Back-to-back, then reset in mid-run
    // ----------------------------------------------------------------
    @(posedge clk_sys);
    insn_valid <= 1'b1;
    insn       <= rows[0].i;
    @(posedge clk_sys);
    insn <= rows[1].i;
    #1;
    `CHK("first of pair", 16'h8000, wb.data)
    @(posedge clk_sys);
    insn_valid <= 1'b0;
    #1;
    `CHK("second of pair", 16'h0000, wb.data)
    `CHK("pair flags", 5'h19, flags)
    @(posedge clk_sys);
    rst_n <= 1'b0;
    #1;
    `CHK("mid reset flags", 5'h00, flags)
    @(posedge clk_sys);
    rst_n <= 1'b1;
    drive(rows[12].i, 1'b0);
    `CHK("after reset", 16'h0002, wb.data)
    complete_run();
  end
endmodule : test_cpu_insn_subset_exec
